/* File: core/acs_map.svh */
// Register offsets, field positions and codes of the conversion sequencer
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define ACS_ADDR_W         8
`define ACS_OFF_CTRL       8'h00
`define ACS_OFF_MODE       8'h04
`define ACS_OFF_STATUS     8'h08
`define ACS_OFF_IE         8'h0C
`define ACS_PAGE_REGS      2'h0
`define ACS_PAGE_SLOTCTL   2'h1
`define ACS_PAGE_RESULT    2'h2
`define ACS_RESP_OKAY      2'h0
`define ACS_RESP_SLVERR    2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACS_BIT_ENABLE     0
`define ACS_BIT_START      1
`define ACS_MODE_MSB       1
`define ACS_MODE_LSB       0
`define ACS_PTR_MSB        7
`define ACS_PTR_LSB        4
`define ACS_TRIG_MSB       9
`define ACS_TRIG_LSB       8
`define ACS_CW_CH_MSB      3
`define ACS_CW_CH_LSB      0
`define ACS_CW_REF_MSB     6
`define ACS_CW_REF_LSB     4
`define ACS_CW_END_BIT     7
`define ACS_BUSY_BIT       16

// ----------------------------------------------------------------
// Codes, slot count and pointer step
// ----------------------------------------------------------------
`define ACS_MODE_SINGLE    2'h0
`define ACS_MODE_SEQ       2'h1
`define ACS_MODE_RPT_SGL   2'h2
`define ACS_MODE_RPT_SEQ   2'h3
`define ACS_TRIG_SOFTWARE  2'h0
`define ACS_TRIG_ONE       2'h1
`define ACS_TRIG_TWO       2'h2
`define ACS_TRIG_THREE     2'h3
`define ACS_SLOTS          16
`define ACS_PTR_STEP       4'h1

`endif

/* File: core/acs_pkg.sv */
// Types shared by the conversion sequencer and its result memory
package acs_pkg;

	typedef enum logic {SEQ_IDLE, SEQ_CONVERT} acs_seq_t;
	typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} acs_rd_t;
	typedef enum logic [2:0] {REG_CTRL, REG_MODE, REG_STATUS, REG_IE,
		REG_SLOTCTL, REG_RESULT, REG_NONE} acs_region_t;

	// Request to the analog core
	typedef struct packed {
		logic       start;      // One-cycle pulse
		logic       abort;      // One-cycle pulse
		logic [3:0] channel;
		logic [2:0] reference;
		logic [3:0] slot;
	} acs_conv_req_t;

	// Answer from the analog core
	typedef struct packed {
		logic        done;      // One-cycle pulse
		logic [11:0] result;
	} acs_conv_done_t;

	typedef struct packed {
		// Bus side
		logic              aw_held;
		logic [7:0]        awaddr;
		logic              w_held;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		acs_rd_t           rd_phase;
		logic [7:0]        araddr;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		// Software visible
		logic              enable;
		logic [1:0]        mode;
		logic [3:0]        start_ptr;
		logic [1:0]        trig_sel;
		logic [15:0]       ie;
		logic [15:0]       done;
		logic [15:0][7:0]  ctl;
		logic              irq;
		// Sequencer
		acs_seq_t          fsm;
		logic [3:0]        ptr;
		logic [1:0]        act_mode;
		logic              armed;
		logic [2:0]        trig_prev;
		acs_conv_req_t     req;
	} acs_state_t;

	typedef struct packed {
		logic [15:0][11:0] words;
		logic [11:0]       rdata;
	} acs_mem_state_t;

endpackage

/* File: core/acs_result_mem.sv */
// Sixteen-slot result memory with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "acs_map.svh"

module acs_result_mem (
	input  wire logic        clock_in,    // Block clock
	input  wire logic        sys_rst_in,  // Async reset, high
	input  wire logic        we_in,       // Store a result
	input  wire logic [3:0]  waddr_in,    // Slot written
	input  wire logic [11:0] wdata_in,    // Result value
	input  wire logic [3:0]  raddr_in,    // Slot read
	output var  logic [11:0] rdata_out    // Read data, next cycle
);

	acs_pkg::acs_mem_state_t s;
	acs_pkg::acs_mem_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.rdata = s.words[raddr_in];
		if (we_in) begin
			next_s.words[waddr_in] = wdata_in;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_out = s.rdata;

endmodule // acs_result_mem

`default_nettype wire

/* File: core/acs_sequencer.sv */
// Conversion sequencer for a 12-bit converter with sixteen result slots
`timescale 1ns/10ps
`default_nettype none
`include "acs_map.svh"

module acs_sequencer (
	input  wire logic                    clock_in,       // 40 MHz block clock
	input  wire logic                    sys_rst_in,     // Async reset, high
	// AXI4-Lite slave
	input  wire logic [7:0]              s_axi_awaddr,   // Write address
	input  wire logic                    s_axi_awvalid,  // Write address valid
	output var  logic                    s_axi_awready,  // Write address ready
	input  wire logic [31:0]             s_axi_wdata,    // Write data
	input  wire logic [3:0]              s_axi_wstrb,    // Write byte lanes
	input  wire logic                    s_axi_wvalid,   // Write data valid
	output var  logic                    s_axi_wready,   // Write data ready
	output var  logic [1:0]              s_axi_bresp,    // Write response
	output var  logic                    s_axi_bvalid,   // Write response valid
	input  wire logic                    s_axi_bready,   // Write response ready
	input  wire logic [7:0]              s_axi_araddr,   // Read address
	input  wire logic                    s_axi_arvalid,  // Read address valid
	output var  logic                    s_axi_arready,  // Read address ready
	output var  logic [31:0]             s_axi_rdata,    // Read data
	output var  logic [1:0]              s_axi_rresp,    // Read response
	output var  logic                    s_axi_rvalid,   // Read data valid
	input  wire logic                    s_axi_rready,   // Read data ready
	// Trigger sources one to three
	input  wire logic [2:0]              trigger_in,     // Rising edge starts
	// Analog core
	output var  acs_pkg::acs_conv_req_t  conv_req_out,   // Start, abort, selection
	input  wire acs_pkg::acs_conv_done_t conv_done_in,   // Completion and result
	// Status
	output var  logic [15:0]             slot_done_out,  // Slot done flags
	output var  logic                    irq_req_out,    // Enabled done flag pending
	output var  logic                    busy_out        // Conversion in progress
);

	acs_pkg::acs_state_t s;
	acs_pkg::acs_state_t next_s;
	logic [11:0]         mem_rdata;
	logic                mem_we;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic acs_pkg::acs_region_t decode(input logic [7:0] addr);
		acs_pkg::acs_region_t r;
		r = acs_pkg::REG_NONE;
		if (addr[1:0] == 2'h0) begin
			unique case (addr[7:6])
				`ACS_PAGE_SLOTCTL: r = acs_pkg::REG_SLOTCTL;
				`ACS_PAGE_RESULT:  r = acs_pkg::REG_RESULT;
				`ACS_PAGE_REGS: begin
					if (addr == `ACS_OFF_CTRL) r = acs_pkg::REG_CTRL;
					else if (addr == `ACS_OFF_MODE) r = acs_pkg::REG_MODE;
					else if (addr == `ACS_OFF_STATUS) r = acs_pkg::REG_STATUS;
					else if (addr == `ACS_OFF_IE) r = acs_pkg::REG_IE;
				end
				default: r = acs_pkg::REG_NONE;
			endcase
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		acs_pkg::acs_region_t wr_reg;
		acs_pkg::acs_region_t rd_reg;
		logic [31:0]          old_word;
		logic [31:0]          m;
		logic                 sw_start;
		logic [2:0]           trig_rise;
		logic                 hw_trig;
		logic                 start_req;
		logic                 launch;
		logic [3:0]           launch_ptr;
		logic [1:0]           launch_mode;
		logic                 end_flag;
		logic [3:0]           wslot;
		logic [3:0]           rslot;

		next_s      = s;
		sw_start    = 1'b0;
		launch      = 1'b0;
		launch_ptr  = s.ptr;
		launch_mode = s.act_mode;
		mem_we      = 1'b0;
		old_word    = '0;
		m           = '0;
		hw_trig     = 1'b0;
		start_req   = 1'b0;
		trig_rise   = 3'h0;
		end_flag    = 1'b0;
		wslot       = s.awaddr[5:2];
		rslot       = s.araddr[5:2];
		wr_reg      = decode(s.awaddr);
		rd_reg      = decode(s.araddr);
		next_s.req.start = 1'b0;
		next_s.req.abort = 1'b0;

		// ---------------- Write channel ----------------
		if (s_axi_awvalid && !s.aw_held && !s.bvalid) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_held && !s.bvalid) begin
			next_s.w_held = 1'b1;
			next_s.wdata  = s_axi_wdata;
			next_s.wstrb  = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_held && s.w_held) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = `ACS_RESP_OKAY;
			unique case (wr_reg)
				acs_pkg::REG_CTRL: begin
					if (s.wstrb[0]) begin
						next_s.enable = s.wdata[`ACS_BIT_ENABLE];
						sw_start = s.wdata[`ACS_BIT_START];
					end
				end
				acs_pkg::REG_MODE: begin
					old_word[`ACS_MODE_MSB:`ACS_MODE_LSB] = s.mode;
					old_word[`ACS_PTR_MSB:`ACS_PTR_LSB]   = s.start_ptr;
					old_word[`ACS_TRIG_MSB:`ACS_TRIG_LSB] = s.trig_sel;
					m = merge(old_word, s.wdata, s.wstrb);
					next_s.mode      = m[`ACS_MODE_MSB:`ACS_MODE_LSB];
					next_s.start_ptr = m[`ACS_PTR_MSB:`ACS_PTR_LSB];
					next_s.trig_sel  = m[`ACS_TRIG_MSB:`ACS_TRIG_LSB];
				end
				acs_pkg::REG_STATUS: begin
					// Write one to clear; a set below in this cycle still wins
					next_s.done = s.done & ~16'(merge(32'h0000_0000, s.wdata, s.wstrb));
				end
				acs_pkg::REG_IE: begin
					m = merge({16'h0000, s.ie}, s.wdata, s.wstrb);
					next_s.ie = m[15:0];
				end
				acs_pkg::REG_SLOTCTL: begin
					if (s.wstrb[0]) begin
						next_s.ctl[wslot] = s.wdata[7:0];
					end
				end
				default: next_s.bresp = `ACS_RESP_SLVERR;
			endcase
		end

		// ---------------- Read channel ----------------
		unique case (s.rd_phase)
			acs_pkg::RD_IDLE: begin
				if (s_axi_arvalid) begin
					next_s.araddr   = s_axi_araddr;
					next_s.rd_phase = acs_pkg::RD_FETCH;
				end
			end
			acs_pkg::RD_FETCH: begin
				next_s.rdata  = '0;
				next_s.rresp  = `ACS_RESP_OKAY;
				next_s.rvalid = 1'b1;
				unique case (rd_reg)
					acs_pkg::REG_CTRL:   next_s.rdata[`ACS_BIT_ENABLE] = s.enable;
					acs_pkg::REG_MODE: begin
						next_s.rdata[`ACS_MODE_MSB:`ACS_MODE_LSB] = s.mode;
						next_s.rdata[`ACS_PTR_MSB:`ACS_PTR_LSB]   = s.start_ptr;
						next_s.rdata[`ACS_TRIG_MSB:`ACS_TRIG_LSB] = s.trig_sel;
					end
					acs_pkg::REG_STATUS: begin
						next_s.rdata[15:0] = s.done;
						next_s.rdata[`ACS_BUSY_BIT] = (s.fsm == acs_pkg::SEQ_CONVERT);
					end
					acs_pkg::REG_IE:      next_s.rdata[15:0] = s.ie;
					acs_pkg::REG_SLOTCTL: next_s.rdata[7:0] = s.ctl[rslot];
					acs_pkg::REG_RESULT:  next_s.rdata[11:0] = mem_rdata;
					default:              next_s.rresp = `ACS_RESP_SLVERR;
				endcase
				next_s.rd_phase = acs_pkg::RD_RESP;
			end
			acs_pkg::RD_RESP: begin
				if (s_axi_rready) begin
					next_s.rvalid   = 1'b0;
					next_s.rd_phase = acs_pkg::RD_IDLE;
				end
			end
			default: next_s.rd_phase = acs_pkg::RD_IDLE;
		endcase

		// ---------------- Start conditions ----------------
		trig_rise        = trigger_in & ~s.trig_prev;
		next_s.trig_prev = trigger_in;
		unique case (s.trig_sel)
			`ACS_TRIG_ONE:   hw_trig = trig_rise[0];
			`ACS_TRIG_TWO:   hw_trig = trig_rise[1];
			`ACS_TRIG_THREE: hw_trig = trig_rise[2];
			default:         hw_trig = 1'b0;
		endcase
		// Enable low re-arms external triggers
		if (!next_s.enable) begin
			next_s.armed = 1'b1;
		end
		// Start uses the enable value of the same write
		if (s.trig_sel == `ACS_TRIG_SOFTWARE) begin
			start_req = next_s.enable && sw_start;
		end else begin
			start_req = next_s.enable && hw_trig && s.armed;
		end

		// ---------------- Sequencer ----------------
		unique case (s.fsm)
			acs_pkg::SEQ_IDLE: begin
				if (start_req) begin
					launch      = 1'b1;
					launch_ptr  = s.start_ptr;
					launch_mode = next_s.mode;
				end
			end
			acs_pkg::SEQ_CONVERT: begin
				if (!next_s.enable && next_s.mode == `ACS_MODE_SINGLE) begin
					// Emergency stop: result dropped, flag not set
					next_s.req.abort = 1'b1;
					next_s.fsm       = acs_pkg::SEQ_IDLE;
				end else if (conv_done_in.done) begin
					mem_we = 1'b1;
					next_s.done[s.ptr] = 1'b1;
					end_flag = s.ctl[s.ptr][`ACS_CW_END_BIT];
					next_s.fsm = acs_pkg::SEQ_IDLE;
					unique case (s.act_mode)
						`ACS_MODE_SINGLE: begin
							// New mode only seen at the next start
							next_s.fsm = acs_pkg::SEQ_IDLE;
						end
						`ACS_MODE_RPT_SGL: begin
							// End flags play no part here
							if (next_s.enable && next_s.mode == `ACS_MODE_RPT_SGL) begin
								launch      = 1'b1;
								launch_ptr  = s.ptr;
								launch_mode = `ACS_MODE_RPT_SGL;
							end else if (next_s.enable && next_s.mode == `ACS_MODE_RPT_SEQ) begin
								launch      = 1'b1;
								launch_ptr  = s.start_ptr;
								launch_mode = `ACS_MODE_RPT_SEQ;
							end
						end
						default: begin
							if (next_s.mode == `ACS_MODE_SINGLE) begin
								// Completed results stay valid
								next_s.fsm = acs_pkg::SEQ_IDLE;
							end else if (next_s.mode == `ACS_MODE_RPT_SGL
								&& s.act_mode == `ACS_MODE_RPT_SEQ && next_s.enable) begin
								launch      = 1'b1;
								launch_ptr  = s.start_ptr;
								launch_mode = `ACS_MODE_RPT_SGL;
							end else if (!end_flag) begin
								// Sequence runs on regardless of enable unless mode was set to single, or, with enable high, a repeat sequence to repeat single
								launch      = 1'b1;
								launch_ptr  = 4'(s.ptr + `ACS_PTR_STEP);
								launch_mode = s.act_mode;
							end else if (next_s.enable && next_s.mode == `ACS_MODE_RPT_SEQ) begin
								launch      = 1'b1;
								launch_ptr  = s.start_ptr;
								launch_mode = `ACS_MODE_RPT_SEQ;
							end else if (next_s.enable && next_s.mode == `ACS_MODE_RPT_SGL) begin
								launch      = 1'b1;
								launch_ptr  = s.start_ptr;
								launch_mode = `ACS_MODE_RPT_SGL;
							end else begin
								next_s.fsm = acs_pkg::SEQ_IDLE;
							end
						end
					endcase
				end
			end
		endcase

		if (launch) begin
			next_s.fsm           = acs_pkg::SEQ_CONVERT;
			next_s.ptr           = launch_ptr;
			next_s.act_mode      = launch_mode;
			next_s.req.start     = 1'b1;
			next_s.req.slot      = launch_ptr;
			next_s.req.channel   = s.ctl[launch_ptr][`ACS_CW_CH_MSB:`ACS_CW_CH_LSB];
			next_s.req.reference = s.ctl[launch_ptr][`ACS_CW_REF_MSB:`ACS_CW_REF_LSB];
			if (s.trig_sel != `ACS_TRIG_SOFTWARE && s.fsm == acs_pkg::SEQ_IDLE) begin
				next_s.armed = 1'b0;
			end
		end

		next_s.irq = |(next_s.done & next_s.ie);
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Result memory
	// ----------------------------------------------------------------
	acs_result_mem u_mem (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.we_in      (mem_we),
		.waddr_in   (s.ptr),
		.wdata_in   (conv_done_in.result),
		.raddr_in   (next_s.araddr[5:2]),
		.rdata_out  (mem_rdata)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !s.aw_held && !s.bvalid;
	assign s_axi_wready  = !s.w_held && !s.bvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = (s.rd_phase == acs_pkg::RD_IDLE);
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign conv_req_out  = s.req;
	assign slot_done_out = s.done;
	assign irq_req_out   = s.irq;
	assign busy_out      = (s.fsm == acs_pkg::SEQ_CONVERT);

endmodule // acs_sequencer

`default_nettype wire

/* File: dv/acs_core_model.sv */
// Behavioural analog core answering the sequencer
`timescale 1ns/10ps
`default_nettype none

module acs_core_model (
	input  wire logic                    clock_in,    // Block clock
	input  wire logic                    sys_rst_in,  // Async reset, high
	input  wire logic [7:0]              lat_in,      // Start to done, 2 or more
	input  wire acs_pkg::acs_conv_req_t  req_in,      // Request from sequencer
	output var  acs_pkg::acs_conv_done_t done_out     // Completion and result
);
	logic [7:0]  cnt;
	logic [11:0] res;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt <= 8'h00;
			res <= 12'h000;
			done_out <= '0;
		end else begin
			done_out.done <= 1'b0;
			// Stale result scrambled so a late read cannot pass by luck
			done_out.result <= ~done_out.result;
			if (req_in.abort) begin
				cnt <= 8'h00;
			end else if (req_in.start) begin
				cnt <= lat_in;
				res <= {req_in.slot, 1'b0, req_in.reference, req_in.channel};
			end else if (cnt == 8'h01) begin
				cnt <= 8'h00;
				done_out <= {1'b1, res};
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule // acs_core_model

`default_nettype wire

/* File: dv/acs_sequencer_chk.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/10ps
`default_nettype none

module acs_sequencer_chk (
	input wire logic clock_in, sys_rst_in, s_axi_awready, s_axi_wready, s_axi_bvalid,
	input wire logic s_axi_bready, s_axi_rvalid, s_axi_rready, busy_out,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [15:0] slot_done_out,
	input wire acs_pkg::acs_conv_req_t conv_req_out,
	input wire acs_pkg::acs_conv_done_t conv_done_in
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	start_pulse_a: assert property (conv_req_out.start |=> !conv_req_out.start)
		else $error("start longer than one cycle");
	start_busy_a: assert property (conv_req_out.start |-> busy_out)
		else $error("start without busy");
	sel_stable_a: assert property (!conv_req_out.start |-> $stable(conv_req_out[10:0]))
		else $error("selection moved between starts");
	flag_set_a: assert property (conv_done_in.done && busy_out && !conv_req_out.abort
		|=> slot_done_out[$past(conv_req_out.slot)]) else $error("done flag not set");
	flag_cause_a: assert property ((slot_done_out & ~$past(slot_done_out)) != 16'h0000
		|-> $past(conv_done_in.done && busy_out)) else $error("flag set without done");
	abort_idle_a: assert property (conv_req_out.abort |=> !busy_out && !conv_req_out.start)
		else $error("busy after abort");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
endmodule // acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk i_chk (.clock_in, .sys_rst_in, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .busy_out, .s_axi_rdata,
	.slot_done_out, .conv_req_out, .conv_done_in);

`default_nettype wire

/* File: dv/test_adc_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none

module test_adc_conversion_sequencer;
	logic clock_in, sys_rst_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic busy_out, irq_req_out;
	logic [7:0] s_axi_awaddr, s_axi_araddr, lat;
	logic [31:0] s_axi_wdata, s_axi_rdata, rs, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] trigger_in;
	logic [15:0] slot_done_out;
	acs_pkg::acs_conv_req_t conv_req_out;
	acs_pkg::acs_conv_done_t conv_done_in;
	logic [7:0] cw [16];
	logic [10:0] q [$];
	int l [$];
	int errors, check_count;

	acs_sequencer i_dut (.clock_in, .sys_rst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .trigger_in, .conv_req_out, .conv_done_in, .slot_done_out,
		.irq_req_out, .busy_out);
	acs_core_model i_core (.clock_in, .sys_rst_in, .lat_in(lat), .req_in(conv_req_out),
		.done_out(conv_done_in));

	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	always @(posedge clock_in) if (conv_req_out.start === 1'b1) q.push_back(conv_req_out[10:0]);

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic logic [11:0] exp_res(input int s);
		return {s[3:0], 1'b0, cw[s][6:0]};
	endfunction

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		@(posedge clock_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		cmp("bresp", r, s_axi_bresp);
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] v);
		@(posedge clock_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		cmp("rresp", r, s_axi_rresp);
	endtask

	// Busy stays high between steps; wait for a quiet stretch of six cycles
	task automatic idle();
		int n, k;
		n = 0;
		k = 0;
		while (k < 6 && n < 3000) begin
			@(posedge clock_in);
			n++;
			k = (busy_out === 1'b0) ? k + 1 : 0;
		end
	endtask

	task automatic chk(input int s [$]);
		logic [15:0] f;
		f = 16'h0000;
		cmp("count", s.size(), q.size());
		foreach (s[i]) if (i < q.size()) begin
			cmp("slot", s[i], q[i][3:0]);
			cmp("chref", cw[s[i]][6:0], {q[i][6:4], q[i][10:7]});
			rd({2'b10, 4'(s[i]), 2'b00}, 2'h0, d);
			cmp("result", exp_res(s[i]), d);
			f[s[i]] = 1'b1;
		end
		rd(8'h08, 2'h0, d);
		cmp("flags", f, d);
		cmp("doneout", f, slot_done_out);
		cmp("irq", |(f & 16'hFFF0), irq_req_out);
		wr(8'h08, 32'hFFFF, 2'h0);
		q.delete();
	endtask

	task automatic run(input logic [1:0] m, input logic [3:0] p, input int s [$]);
		wr(8'h04, {24'h0, p, 2'b00, m}, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		idle();
		chk(s);
	endtask

	task automatic trig(input logic [2:0] t);
		@(posedge clock_in);
		trigger_in <= t;
		@(posedge clock_in);
		trigger_in <= 3'b000;
		idle();
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock_in);
		errors++;
		summarize();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		trigger_in = 3'b000;
		lat = 8'h04;
		rs = 32'h582A;
		sys_rst_in = 1'b1;
		repeat (4) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(8'(i * 4), 2'h0, d);
			cmp("reset", 32'h0, d);
		end
		rd(8'h10, 2'h2, d);
		rd(8'h42, 2'h2, d);
		wr(8'h80, 32'h1, 2'h2);
		wr(8'h0C, 32'hFFF0, 2'h0);
		for (int i = 0; i < 16; i++) begin
			rs = lfsr(rs);
			cw[i] = {i == 1 || i == 3, rs[6:0]};
			wr({2'b01, 4'(i), 2'b00}, cw[i], 2'h0);
		end
		rd(8'h54, 2'h0, d);
		cmp("ctlword", cw[5], d);
		for (int k = 0; k < 3; k++) begin
			rs = lfsr(rs);
			lat <= 8'h02 + rs[2:0];
			run(2'h0, rs[7:4], '{rs[7:4]});
		end
		wr(8'h00, 32'h3, 2'h0);
		idle();
		chk('{rs[7:4]});
		run(2'h1, 4'h2, '{2, 3});
		run(2'h1, 4'hE, '{14, 15, 0, 1});
		wr(8'h04, 32'h12, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		repeat (60) @(posedge clock_in);
		wr(8'h04, 32'h10, 2'h0);
		idle();
		cmp("repeats", 1, q.size() > 2);
		l.delete();
		foreach (q[i]) l.push_back(1);
		chk(l);
		wr(8'h04, 32'h23, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		repeat (80) @(posedge clock_in);
		wr(8'h04, 32'h21, 2'h0);
		idle();
		cmp("seqreps", 1, q.size() > 2 && q.size() % 2 == 0);
		l.delete();
		foreach (q[i]) l.push_back(2 + i % 2);
		chk(l);
		lat <= 8'h3C;
		wr(8'h04, 32'h50, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		repeat (10) @(posedge clock_in);
		wr(8'h00, 32'h0, 2'h0);
		idle();
		repeat (70) @(posedge clock_in);
		cmp("aborted", 1, q.size());
		rd(8'h08, 2'h0, d);
		cmp("noflag", 32'h0, d);
		q.delete();
		// Emergency stop of a running sequence
		wr(8'h04, 32'h21, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		repeat (10) @(posedge clock_in);
		wr(8'h04, 32'h20, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
		idle();
		repeat (70) @(posedge clock_in);
		cmp("stopped", 1, q.size());
		cmp("stopbusy", 0, busy_out);
		wr(8'h08, 32'hFFFF, 2'h0);
		q.delete();
		lat <= 8'h04;
		wr(8'h04, 32'h150, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		trig(3'b110);
		trig(3'b001);
		trig(3'b001);
		wr(8'h00, 32'h0, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		trig(3'b001);
		chk('{5, 5});
		summarize();
	end
endmodule // test_adc_conversion_sequencer

`default_nettype wire
